// *** adc_readout_cfg.svh ***
// Purpose: Constants for the serial readout side of a 20-bit converter.
// Assumes: System clock of 10 MHz; all times are counted in its cycles.
// Notes:   Long counts are parameters of the top module with these defaults.
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH

// Clock rate in MHz, used to turn microseconds into cycles
`define CLK_MHZ 10
// Result layout
`define RESULT_W 20
`define SAMPLE_W 24
`define CODE_MAX 20'h7FFFF
`define CODE_MIN 20'h80000
// Serial pulse counts
`define PAD_LAST 5'h18
`define CAL_PULSE 5'h1A
// Times in microseconds at the nominal device clock
`define CONV_FAST_US 12500
`define CONV_SLOW_US 100000
`define UPDATE_US 39
`define CAL_FAST_US 101280
`define CAL_SLOW_US 801020
// Times in cycles
`define CONV_FAST_CYC (`CONV_FAST_US * `CLK_MHZ)
`define CONV_SLOW_CYC (`CONV_SLOW_US * `CLK_MHZ)
`define UPDATE_CYC (`UPDATE_US * `CLK_MHZ)
`define CAL_FAST_CYC (`CAL_FAST_US * `CLK_MHZ)
`define CAL_SLOW_CYC (`CAL_SLOW_US * `CLK_MHZ)
// Width of the interval counter
`define CNT_W 24

`endif

// *** adc_readout_pkg.sv ***
// Purpose: Types for the serial readout block.
// Assumes: Constants come from adc_readout_cfg.svh.
// Notes:   Types only; no numbers live here beyond state codes.
`include "adc_readout_cfg.svh"

package adc_readout_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_CONV   = 2'b00,
    ST_UPDATE = 2'b01,
    ST_CAL    = 2'b10
  } seq_state_t;

  // Pin-side outputs that travel together
  typedef struct packed {
    logic line;
    logic cal_active;
    logic input_short;
  } pin_out_t;

endpackage : adc_readout_pkg

// *** result_clip.sv ***
// Purpose: Saturate a wide filter sample to a 20-bit two's complement code.
// Assumes: Sample is signed and on the same clock as the readout.
// Notes:   Output is registered so the loaded result is glitch free.
`timescale 1ns/1ns
`include "adc_readout_cfg.svh"

module result_clip
  import adc_readout_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Wide sample in
  input wire logic signed [`SAMPLE_W-1:0] i_sample,
  // Clipped code out
  output logic [`RESULT_W-1:0] o_code
);

  logic [`RESULT_W-1:0] code_r; // Held code
  logic [`RESULT_W-1:0] code_nxt; // Next code
  logic signed [`SAMPLE_W-1:0] max_w; // Widened limits for compare
  logic signed [`SAMPLE_W-1:0] min_w;

  // Sign-extend the clip limits to the sample width
  assign max_w = {{(`SAMPLE_W-`RESULT_W){1'b0}}, `CODE_MAX};
  assign min_w = {{(`SAMPLE_W-`RESULT_W){1'b1}}, `CODE_MIN};

  // Saturation: anything beyond full scale pins to the end code
  always_comb begin
    if (i_sample > max_w) begin
      code_nxt = `CODE_MAX;
    end else if (i_sample < min_w) begin
      code_nxt = `CODE_MIN;
    end else begin
      code_nxt = i_sample[`RESULT_W-1:0];
    end
  end

  // Register the code
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      code_r <= 20'h00000;
    end else begin
      code_r <= code_nxt;
    end
  end

  assign o_code = code_r;

endmodule : result_clip

// *** adc_serial_readout.sv ***
// Purpose: Conversion pacing, ready/data line and offset calibration trigger.
// Assumes: Serial clock and rate select are pins, resynchronised here.
// Notes:   Serial clock edges are found by sampling, so it must stay well
//          below the system clock (it is specified slower than 5 MHz).
`timescale 1ns/1ns
`include "adc_readout_cfg.svh"

module adc_serial_readout
  import adc_readout_pkg::*;
#(
  parameter logic [`CNT_W-1:0] P_CONV_FAST = `CNT_W'(`CONV_FAST_CYC),
  parameter logic [`CNT_W-1:0] P_CONV_SLOW = `CNT_W'(`CONV_SLOW_CYC),
  parameter logic [`CNT_W-1:0] P_CAL_FAST = `CNT_W'(`CAL_FAST_CYC),
  parameter logic [`CNT_W-1:0] P_CAL_SLOW = `CNT_W'(`CAL_SLOW_CYC)
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pins from the host
  input wire logic i_sclk,
  input wire logic i_rate_sel,
  // Filter output, same clock domain
  input wire logic signed [`SAMPLE_W-1:0] i_sample,
  // Pins and controls out
  output logic o_ready_serial_out,
  output logic o_cal_active,
  output logic o_input_short
);

  localparam logic [`CNT_W-1:0] UPD_CYC = `CNT_W'(`UPDATE_CYC);

  // Synchronisers: stage 1 feeds only stage 2
  logic [2:0] sclk_sync_r; // [0] first, [1] second, [2] edge history
  logic [1:0] rate_sync_r;
  logic sclk_rise;
  logic sclk_fall;
  logic rate_fast;

  // Sequencer state
  seq_state_t state_r, state_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt; // Interval counter
  logic [4:0] bitcnt_r, bitcnt_nxt; // Rising edges seen since ready
  logic have_data_r, have_data_nxt; // Result waiting to be read
  logic [`RESULT_W-1:0] shadow_r, shadow_nxt; // Result being shifted
  pin_out_t pins_r, pins_nxt; // Registered pin outputs

  // Clipped code from the filter
  logic [`RESULT_W-1:0] code;
  logic [`CNT_W-1:0] period;
  logic [`CNT_W-1:0] cal_period;

  result_clip u_clip (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sample(i_sample),
    .o_code(code)
  );

  // Pin resynchronisation, edge search on stages 2 and 3
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_sync_r <= 3'h0;
      rate_sync_r <= 2'h0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], i_sclk};
      rate_sync_r <= {rate_sync_r[0], i_rate_sel};
    end
  end

  assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2];
  assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2];
  assign rate_fast = rate_sync_r[1];

  // Intervals picked by rate, all counted on this clock
  assign period = rate_fast ? P_CONV_FAST : P_CONV_SLOW;
  assign cal_period = rate_fast ? P_CAL_FAST : P_CAL_SLOW;

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + `CNT_W'(1);
    bitcnt_nxt = bitcnt_r;
    have_data_nxt = have_data_r;
    shadow_nxt = shadow_r;
    pins_nxt = pins_r;
    case (state_r)
      ST_CONV: begin
        // Free-running conversion; rate change uses >= so it cannot stall
        if (cnt_r >= period - UPD_CYC - `CNT_W'(1)) begin
          state_nxt = ST_UPDATE;
          pins_nxt.line = 1'b1;
          have_data_nxt = 1'b0;
        end else if (sclk_fall && have_data_r && bitcnt_r == `CAL_PULSE) begin
          // Falling edge of pulse 26 starts calibration
          state_nxt = ST_CAL;
          cnt_nxt = '0;
          have_data_nxt = 1'b0;
          pins_nxt.line = 1'b1;
          pins_nxt.cal_active = 1'b1;
          pins_nxt.input_short = 1'b1;
        end else if (sclk_rise && have_data_r) begin
          if (bitcnt_r < 5'(`RESULT_W)) begin
            // MSB on first edge, next bit on each later one
            pins_nxt.line = shadow_r[5'h13 - bitcnt_r];
          end else begin
            // Padding ones, and pulse 25 keeps the line high
            pins_nxt.line = 1'b1;
          end
          if (bitcnt_r != 5'h1F) begin
            bitcnt_nxt = bitcnt_r + 5'h01;
          end
        end
        // With no edge the line simply holds its last bit
      end
      ST_UPDATE: begin
        // Blackout: host edges are ignored, line held high
        if (cnt_r >= period - `CNT_W'(1)) begin
          state_nxt = ST_CONV;
          cnt_nxt = '0;
          shadow_nxt = code;
          have_data_nxt = 1'b1;
          bitcnt_nxt = 5'h00;
          pins_nxt.line = 1'b0;
        end
      end
      ST_CAL: begin
        // Further serial pulses cannot abort the cycle
        if (cnt_r >= cal_period - `CNT_W'(1)) begin
          state_nxt = ST_CONV;
          cnt_nxt = '0;
          shadow_nxt = code;
          have_data_nxt = 1'b1;
          bitcnt_nxt = 5'h00;
          pins_nxt.line = 1'b0;
          pins_nxt.cal_active = 1'b0;
          pins_nxt.input_short = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_CONV;
        cnt_nxt = '0;
      end
    endcase
  end

  // Sequencer registers; the line idles high until the first result
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_CONV;
      cnt_r <= '0;
      bitcnt_r <= 5'h00;
      have_data_r <= 1'b0;
      shadow_r <= 20'h00000;
      pins_r <= '{line: 1'b1, cal_active: 1'b0, input_short: 1'b0};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bitcnt_r <= bitcnt_nxt;
      have_data_r <= have_data_nxt;
      shadow_r <= shadow_nxt;
      pins_r <= pins_nxt;
    end
  end

  assign o_ready_serial_out = pins_r.line;
  assign o_cal_active = pins_r.cal_active;
  assign o_input_short = pins_r.input_short;

endmodule : adc_serial_readout

// *** adc_serial_readout_asserts.sv ***
// Purpose: Checker on the pins of the serial readout block.
// Assumes: Bound to adc_serial_readout; one clock domain.
// Notes: Calibration length is held in a 24-bit cycle counter.
`timescale 1ns/1ns
`include "adc_readout_cfg.svh"
module adc_serial_readout_asserts #(
  parameter logic [`CNT_W-1:0] P_CAL_FAST = 24'h1,
  parameter logic [`CNT_W-1:0] P_CAL_SLOW = 24'h1
)(
  // Clock, reset and host pins
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_rate_sel,
  // Device pins
  input wire logic o_ready_serial_out,
  input wire logic o_cal_active,
  input wire logic o_input_short
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Cycles spent calibrating so far
  logic [`CNT_W-1:0] cal_cnt_r, cal_cnt_nxt, cal_exp;
  always_comb cal_cnt_nxt = o_cal_active ? cal_cnt_r + 1'b1 : '0;
  always_ff @(posedge i_clk) cal_cnt_r <= i_sys_rst ? '0 : cal_cnt_nxt;
  assign cal_exp = i_rate_sel ? P_CAL_FAST : P_CAL_SLOW;
  sequence cal_start_s; $rose(o_cal_active); endsequence
  sequence cal_end_s; $fell(o_cal_active); endsequence
  a_short_tracks_cal: assert property (
    o_input_short == o_cal_active) else $error("input short differs from calibration");
  a_reset_quiet_line: assert property (
    $fell(i_sys_rst) |-> (o_ready_serial_out && !o_cal_active)[*8])
    else $error("line not idle after reset");
  a_cal_line_high: assert property (
    o_cal_active |-> o_ready_serial_out) else $error("line low while calibrating");
  a_cal_end_ready: assert property (
    cal_end_s |-> !o_ready_serial_out[*3]) else $error("no ready at calibration end");
  a_cal_not_aborted: assert property (
    cal_start_s |-> o_cal_active[*8]) else $error("calibration ended early");
  a_cal_on_fall: assert property (
    cal_start_s |-> !i_sclk && !$past(i_sclk, 2)) else $error("calibration not on a fall");
  a_cal_after_pad: assert property (
    cal_start_s |-> $past(o_ready_serial_out)) else $error("line low before calibration");
  a_cal_length: assert property (
    cal_end_s |-> cal_cnt_r + 2 >= cal_exp && cal_cnt_r <= cal_exp + 2)
    else $error("calibration length wrong");
endmodule : adc_serial_readout_asserts
bind adc_serial_readout adc_serial_readout_asserts #(.P_CAL_FAST(P_CAL_FAST),
  .P_CAL_SLOW(P_CAL_SLOW)) i_adc_serial_readout_asserts (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_sclk(i_sclk), .i_rate_sel(i_rate_sel),
  .o_ready_serial_out(o_ready_serial_out), .o_cal_active(o_cal_active),
  .o_input_short(o_input_short));

// *** sclk_host_model.sv ***
// Purpose: Host that clocks results out of the ready/data line.
// Assumes: Called at a falling clock edge; 800 ns serial period.
// Notes: Serial clock rests low between frames.
`timescale 1ns/1ns
module sclk_host_model (
  // Line from the device
  input wire logic i_line,
  // Serial clock out
  output logic o_sclk
);
  initial o_sclk = 1'b0;
  // Bit taken late in the low phase, long after it has settled
  task automatic pulses(input int n, output logic [25:0] bits);
    bits = '1;
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      #400;
      o_sclk = 1'b0;
      #400;
      bits[25-k] = i_line;
    end
  endtask : pulses
endmodule : sclk_host_model

// *** adc_serial_readout_tb.sv ***
// Purpose: Self-checking bench for the serial readout block.
// Assumes: Inputs change at falling clock edges.
// Notes: Periods are cut down through the top parameters.
`timescale 1ns/1ns
`include "adc_readout_cfg.svh"
module adc_serial_readout_tb import adc_readout_pkg::*;;
  localparam logic [`CNT_W-1:0] CF = 24'h7D0, CS = 24'hFA0, KF = 24'hBB8, KS = 24'h1770;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_rate_sel = 1'b1, sclk, line, cal, shrt;
  logic signed [`SAMPLE_W-1:0] i_sample = '0;
  logic [25:0] b;
  int failures = 0, n_tests = 0;
  initial forever #50 i_clk = ~i_clk;
  sclk_host_model i_sclk_host_model (.i_line(line), .o_sclk(sclk));
  adc_serial_readout #(.P_CONV_FAST(CF), .P_CONV_SLOW(CS), .P_CAL_FAST(KF), .P_CAL_SLOW(KS))
    i_adc_serial_readout (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk),
    .i_rate_sel(i_rate_sel), .i_sample(i_sample), .o_ready_serial_out(line),
    .o_cal_active(cal), .o_input_short(shrt));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Rise first, then fall, so a stale ready is never taken
  task automatic wait_ready(output int c);
    c = 0;
    while (line !== 1'b1 && c < 20000) begin
      @(negedge i_clk);
      c++;
    end
    while (line !== 1'b0 && c < 20000) begin
      @(negedge i_clk);
      c++;
    end
    chk("ready", 1'b0, line);
  endtask : wait_ready
  // Clip table, including both saturation sides
  task automatic t_codes;
    logic [23:0] s [7] = '{24'h0, 24'h1, 24'hFFFFFF, 24'h7FFFF, 24'h100000, 24'hF80000, 24'hF00000};
    logic [19:0] e [7] = '{20'h0, 20'h1, 20'hFFFFF, 20'h7FFFF, 20'h7FFFF, 20'h80000, 20'h80000};
    int c;
    for (int k = 0; k < 7; k++) begin
      i_sample = s[k];
      wait_ready(c);
      i_sclk_host_model.pulses(24, b);
      chk("code", e[k], b[25:6]);
      chk("pad", 4'hF, b[5:2]);
    end
    $display("codes done");
  endtask : t_codes
  task automatic t_hold;
    int c;
    i_sample = 24'h2;
    wait_ready(c);
    i_sclk_host_model.pulses(20, b);
    repeat (40) @(negedge i_clk);
    chk("hold", 1'b0, line);
    i_sclk_host_model.pulses(1, b);
    chk("forced", 1'b1, line);
    $display("hold done");
  endtask : t_hold
  task automatic t_rate;
    int c;
    for (int r = 0; r < 2; r++) begin
      i_rate_sel = r[0];
      wait_ready(c);
      wait_ready(c);
      chk("period", 1'b1, c >= (r ? CF : CS) - 1 && c <= (r ? CF : CS) + 1);
    end
    $display("rate done");
  endtask : t_rate
  // Extra pulses mid-calibration are a deliberate stress
  task automatic t_cal;
    int c;
    wait_ready(c);
    i_sclk_host_model.pulses(26, b);
    chk("cal", 1'b1, cal);
    chk("short", 1'b1, shrt);
    i_sclk_host_model.pulses(2, b);
    chk("cal kept", 1'b1, cal);
    wait_ready(c);
    chk("cal time", 1'b1, c > KF - 40 && c <= KF);
    chk("cal off", 1'b0, cal);
    i_sclk_host_model.pulses(24, b);
    chk("cal code", 20'h2, b[25:6]);
    $display("cal done");
  endtask : t_cal
  initial begin
    repeat (3) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_codes();
    t_hold();
    t_rate();
    t_cal();
    results();
  end
  // About 33000 cycles are expected; three times that means a hang
  initial begin
    #10000000;
    failures++;
    results();
  end
endmodule : adc_serial_readout_tb
